// >>> logic/mlfr_addr_next.sv
// Next read address, with optional wrap inside an aligned section
module mlfr_addr_next (
    // Current address
    input wire logic [23:0] addr,
    // Wrap control
    input wire logic wrap_on,
    input wire logic [1:0] wrap_length_field,
    // Following address
    output logic [23:0] addr_nxt
);
    logic [5:0] mask;
    logic [23:0] inc;

    // Section of 8 << length bytes, always inside a page
    always_comb
    begin
        mask = 6'(({3'b000, 3'b111} << wrap_length_field) | 6'h07); // [RULE26]
        inc = 24'(addr + 24'h1); // [RULE24]
        if (wrap_on)
        begin
            addr_nxt = {addr[23:6], (addr[5:0] & ~mask) | (inc[5:0] & mask)}; // [RULE17]
        end
        else
        begin
            addr_nxt = inc;
        end
    end
endmodule

// >>> logic/mlfr_pkg.sv
// Constants and types shared by the multi-lane fast read path
// Functional notes
// RULE1: Dual output read returns two bits per clock
// RULE2: Dual output read has eight dummy clocks
// RULE3: Input lanes ignored during dummy clocks
// RULE4: Host releases lanes before first data fall
// RULE5: Quad output read needs quad enable set
// RULE6: Quad output read has eight dummy clocks
// RULE7: Dual I/O sends address and data two-lane
// RULE8: Eight mode bits follow address, upper nibble
// RULE9: Dual mode pair 10 skips next opcode
// RULE10: Other mode pair values require opcode
// RULE11: Host exits dual continuous with sixteen ones
// RULE12: Quad I/O four lanes, four dummy clocks
// RULE13: Quad I/O rejected without quad enable
// RULE14: Quad mode pair 10 skips next opcode
// RULE15: Host exits quad continuous with eight ones
// RULE16: Wrap command governs later quad I/O reads
// RULE17: Wrapped output returns to section start
// RULE18: Wrap disable bit and length field
// RULE19: Quad command dummy 2/4/6/8, default 2
// RULE20: Mode bit clocks count as dummy clocks
// RULE21: Continuous mode honoured in quad command mode
// RULE22: No wrap for quad I/O in quad mode
// RULE23: Wrap disable bit resets to one
// RULE24: Address increments after every data byte
// RULE25: Quad command mode needs quad enable
// RULE26: Length field 00..11 gives 8..64 bytes
// RULE27: Chip select rise ends read, rearms decoder
package mlfr_pkg;
    // Opcodes
    localparam logic [7:0] OPC_DOUT2 = 8'h3b;
    localparam logic [7:0] OPC_DOUT4 = 8'h6b;
    localparam logic [7:0] OPC_DIO2 = 8'hbb;
    localparam logic [7:0] OPC_DIO4 = 8'heb;
    localparam logic [7:0] OPC_WRAP = 8'h77;
    // Phase lengths in serial clocks
    localparam logic [5:0] CLK_OPC_SPI = 6'h08;
    localparam logic [5:0] CLK_OPC_QCM = 6'h02;
    localparam logic [5:0] CLK_ADDR_1 = 6'h18;
    localparam logic [5:0] CLK_ADDR_2 = 6'h0c;
    localparam logic [5:0] CLK_ADDR_4 = 6'h06;
    localparam logic [5:0] CLK_DUM_OUT = 6'h08;
    localparam logic [5:0] CLK_DUM_DIO4 = 6'h04;
    localparam logic [5:0] CLK_WRAP_CMD = 6'h20;
    // Mode pair value that arms continuous read
    localparam logic [1:0] CONT_ARM = 2'b10;
    // Field positions
    localparam int MODE_PAIR_LSB = 4;
    localparam int WRAP_LSB = 4;
    localparam int WRAP_DIS_POS = 0;
    // Reset values and bits per byte
    localparam logic [2:0] WRAP_RST = 3'b001;
    localparam logic [1:0] DUMMY_SEL_RST = 2'b00;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    // Reads carried by this path
    typedef enum logic [1:0] {
        MLFR_DOUT2,
        MLFR_DOUT4,
        MLFR_DIO2,
        MLFR_DIO4
    } mlfr_cmd_t;
endpackage

// >>> logic/mlfr_read_path.sv
// Multi-lane fast read command path of the serial flash device
module mlfr_read_path (
    // System clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Serial link pins
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic [3:0] lane_in,
    output logic [3:0] lane_out,
    output logic [3:0] lane_oe,
    // Configuration from the status logic
    input wire logic quad_enable_bit,
    input wire logic quad_command_mode,
    input wire logic dummy_sel_wr,
    input wire logic [1:0] dummy_sel_data,
    // Memory array read port
    output logic [23:0] mem_addr,
    output logic mem_rd,
    input wire logic [7:0] mem_rdata,
    // Status
    output logic [2:0] wrap_setting_bits,
    output logic [1:0] dummy_sel,
    output logic execute_in_place,
    output logic read_busy
);
    import mlfr_pkg::*;

    typedef enum logic [2:0] {
        ST_OPC,
        ST_ADDR,
        ST_MODE,
        ST_DUMMY,
        ST_DATA,
        ST_WRAPC,
        ST_IGNORE
    } mlfr_state_t;

    ////////////////////////////////////////////////////////////////
    // Reset release and pin synchronisation

    logic rst_meta_r;
    logic rst_n_r;
    logic sclk_s;
    logic cs_n_s;
    logic [3:0] lane_s;
    logic sclk_q_r;
    logic sclk_rise;
    logic sclk_fall;
    logic frame_idle;

    // Reset enters asynchronously, leaves through two flops
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rst_meta_r <= 1'b0;
            rst_n_r <= 1'b0;
        end
        else
        begin
            rst_meta_r <= 1'b1;
            rst_n_r <= rst_meta_r;
        end
    end

    mlfr_sync #(
        .W(6),
        .INIT(6'h02)
    ) u_sync (
        .clk(sys_clk),
        .rst_n(rst_n_r),
        .d({lane_in, cs_n, sclk}),
        .q({lane_s, cs_n_s, sclk_s})
    );

    // Serial clock edges found from the synchronised copy
    always_ff @(posedge sys_clk or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            sclk_q_r <= 1'b0;
        end
        else
        begin
            sclk_q_r <= sclk_s;
        end
    end

    assign sclk_rise = sclk_s & ~sclk_q_r & ~cs_n_s;
    assign sclk_fall = ~sclk_s & sclk_q_r & ~cs_n_s;
    assign frame_idle = cs_n_s;

    ////////////////////////////////////////////////////////////////
    // Functions

    // Shift in one clock's worth of lanes, upper lane first
    function automatic logic [31:0] shift_in(input logic [31:0] sh, input logic [2:0] w, input logic [3:0] l);
        logic [31:0] r;
        r = {sh[30:0], l[0]};
        if (w == 3'd2)
        begin
            r = {sh[29:0], l[1:0]};
        end
        else if (w == 3'd4)
        begin
            r = {sh[27:0], l[3:0]};
        end
        return r;
    endfunction

    // Lane enable pattern for a lane count
    function automatic logic [3:0] lane_mask(input logic [2:0] w);
        logic [3:0] m;
        m = 4'h1;
        if (w == 3'd2)
        begin
            m = 4'h3;
        end
        else if (w == 3'd4)
        begin
            m = 4'hf;
        end
        return m;
    endfunction

    ////////////////////////////////////////////////////////////////
    // Command decoder state

    mlfr_state_t st_r;
    mlfr_state_t st_nxt;
    mlfr_cmd_t cmd_r;
    mlfr_cmd_t cmd_nxt;
    logic [5:0] cnt_r;
    logic [5:0] cnt_nxt;
    logic [2:0] w_r;
    logic [2:0] w_nxt;
    logic [31:0] sh_r;
    logic [31:0] sh_nxt;
    logic qact;
    logic qcm_r;
    logic last;
    logic cont_r;
    logic cont_dual_r;
    logic cont_set;
    logic [2:0] wrap_r;
    logic [1:0] dsel_r;
    logic addr_load;
    logic [5:0] dum_clks;

    // Quad command mode only counts while quad enable holds
    assign qact = quad_command_mode & quad_enable_bit; // [RULE25]
    assign last = (cnt_r == 6'h01);
    assign sh_nxt = shift_in(sh_r, w_r, lane_s);

    // Clocks left after mode bits for the quad I/O read
    always_comb
    begin
        dum_clks = CLK_DUM_DIO4; // [RULE12]
        if (qcm_r)
        begin
            dum_clks = {3'b000, dsel_r, 1'b0}; // [RULE19] [RULE20]
        end
    end

    // Phase sequencing on each serial clock rise
    always_comb
    begin
        st_nxt = st_r;
        cmd_nxt = cmd_r;
        w_nxt = w_r;
        cnt_nxt = 6'(cnt_r - 6'h01);
        addr_load = 1'b0;
        cont_set = 1'b0;
        unique case (st_r)
            ST_OPC:
            begin
                if (last)
                begin
                    st_nxt = ST_ADDR;
                    w_nxt = 3'd1;
                    cnt_nxt = CLK_ADDR_1;
                    if (qcm_r)
                    begin
                        // Only quad I/O is carried here in quad command mode
                        cmd_nxt = MLFR_DIO4;
                        w_nxt = 3'd4;
                        cnt_nxt = CLK_ADDR_4;
                        if (sh_nxt[7:0] != OPC_DIO4)
                        begin
                            st_nxt = ST_IGNORE;
                        end
                    end
                    else if (sh_nxt[7:0] == OPC_DOUT2)
                    begin
                        cmd_nxt = MLFR_DOUT2;
                    end
                    else if (sh_nxt[7:0] == OPC_DOUT4)
                    begin
                        cmd_nxt = MLFR_DOUT4;
                        st_nxt = quad_enable_bit ? ST_ADDR : ST_IGNORE; // [RULE5]
                    end
                    else if (sh_nxt[7:0] == OPC_DIO2)
                    begin
                        cmd_nxt = MLFR_DIO2;
                        w_nxt = 3'd2; // [RULE7]
                        cnt_nxt = CLK_ADDR_2;
                    end
                    else if (sh_nxt[7:0] == OPC_DIO4)
                    begin
                        cmd_nxt = MLFR_DIO4;
                        w_nxt = 3'd4; // [RULE12]
                        cnt_nxt = CLK_ADDR_4;
                        st_nxt = quad_enable_bit ? ST_ADDR : ST_IGNORE; // [RULE13]
                    end
                    else if (sh_nxt[7:0] == OPC_WRAP)
                    begin
                        st_nxt = ST_WRAPC;
                        cnt_nxt = CLK_WRAP_CMD;
                    end
                    else
                    begin
                        st_nxt = ST_IGNORE;
                    end
                end
            end
            ST_ADDR:
            begin
                if (last)
                begin
                    addr_load = 1'b1;
                    if (cmd_r == MLFR_DOUT2 || cmd_r == MLFR_DOUT4)
                    begin
                        st_nxt = ST_DUMMY;
                        cnt_nxt = CLK_DUM_OUT; // [RULE2] [RULE6]
                    end
                    else
                    begin
                        st_nxt = ST_MODE;
                        cnt_nxt = 6'(BYTE_BITS / w_r); // [RULE8]
                    end
                end
            end
            ST_MODE:
            begin
                if (last)
                begin
                    cont_set = 1'b1;
                    if (cmd_r == MLFR_DIO2 || dum_clks == 6'h00)
                    begin
                        st_nxt = ST_DATA;
                    end
                    else
                    begin
                        st_nxt = ST_DUMMY;
                        cnt_nxt = dum_clks;
                    end
                end
            end
            ST_DUMMY:
            begin
                // Lane values are shifted but never used here
                if (last)
                begin
                    st_nxt = ST_DATA; // [RULE3]
                end
            end
            ST_WRAPC:
            begin
                if (last)
                begin
                    st_nxt = ST_IGNORE;
                end
            end
            ST_DATA, ST_IGNORE:
            begin
                cnt_nxt = cnt_r;
            end
        endcase
    end

    // Decoder registers; idle chip select rearms the decoder
    always_ff @(posedge sys_clk or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            st_r <= ST_OPC;
            cmd_r <= MLFR_DOUT2;
            cnt_r <= CLK_OPC_SPI;
            w_r <= 3'd1;
            sh_r <= 32'h0000_0000;
            qcm_r <= 1'b0;
        end
        else if (frame_idle)
        begin
            qcm_r <= qact;
            sh_r <= 32'h0000_0000;
            if (cont_r)
            begin
                st_r <= ST_ADDR; // [RULE9] [RULE14] [RULE21] [RULE27]
                cmd_r <= cont_dual_r ? MLFR_DIO2 : MLFR_DIO4;
                w_r <= cont_dual_r ? 3'd2 : 3'd4;
                cnt_r <= cont_dual_r ? CLK_ADDR_2 : CLK_ADDR_4;
            end
            else
            begin
                st_r <= ST_OPC; // [RULE10] [RULE27]
                w_r <= qact ? 3'd4 : 3'd1;
                cnt_r <= qact ? CLK_OPC_QCM : CLK_OPC_SPI;
            end
        end
        else if (sclk_rise)
        begin
            st_r <= st_nxt;
            cmd_r <= cmd_nxt;
            cnt_r <= cnt_nxt;
            w_r <= w_nxt;
            sh_r <= sh_nxt;
        end
    end

    // Continuous read arming from the upper mode nibble
    always_ff @(posedge sys_clk or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            cont_r <= 1'b0;
            cont_dual_r <= 1'b0;
        end
        else if (sclk_rise && cont_set)
        begin
            // Lower nibble is don't care
            cont_r <= (sh_nxt[MODE_PAIR_LSB +: 2] == CONT_ARM); // [RULE8] [RULE9] [RULE10] [RULE14]
            cont_dual_r <= (cmd_r == MLFR_DIO2);
        end
    end

    // Wrap bits from the set-burst-with-wrap command
    always_ff @(posedge sys_clk or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            wrap_r <= WRAP_RST; // [RULE23]
        end
        else if (sclk_rise && st_r == ST_WRAPC && last)
        begin
            wrap_r <= sh_nxt[WRAP_LSB +: 3]; // [RULE16] [RULE18]
        end
    end

    // Dummy setting for quad command mode, default two clocks
    always_ff @(posedge sys_clk or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            dsel_r <= DUMMY_SEL_RST; // [RULE19]
        end
        else if (dummy_sel_wr)
        begin
            dsel_r <= dummy_sel_data;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Data output on serial clock falls

    logic [23:0] addr_r;
    logic [23:0] addr_adv;
    logic [7:0] dsh_r;
    logic [3:0] dleft_r;
    logic [7:0] dbyte;
    logic [3:0] dleft;
    logic [3:0] nib;
    logic wrap_on;
    logic [2:0] out_w;

    // Wrap only for quad I/O issued in single-lane command mode
    assign wrap_on = (cmd_r == MLFR_DIO4) && !qcm_r && !wrap_r[WRAP_DIS_POS]; // [RULE16] [RULE18] [RULE22]
    assign out_w = (cmd_r == MLFR_DOUT2 || cmd_r == MLFR_DIO2) ? 3'd2 : 3'd4; // [RULE1] [RULE5] [RULE7]

    mlfr_addr_next u_addr_next (
        .addr(addr_r),
        .wrap_on(wrap_on),
        .wrap_length_field(wrap_r[2:1]),
        .addr_nxt(addr_adv)
    );

    // Current byte: a fresh array byte or the rest of the last one
    always_comb
    begin
        dbyte = dsh_r;
        dleft = dleft_r;
        if (dleft_r == 4'h0)
        begin
            dbyte = mem_rdata;
            dleft = BYTE_BITS;
        end
        nib = (out_w == 3'd2) ? {2'b00, dbyte[7:6]} : dbyte[7:4];
    end

    // Shift out; address steps as each byte is taken
    always_ff @(posedge sys_clk or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            addr_r <= 24'h00_0000;
            dsh_r <= 8'h00;
            dleft_r <= 4'h0;
        end
        else if (frame_idle)
        begin
            dleft_r <= 4'h0;
        end
        else if (sclk_rise && addr_load)
        begin
            addr_r <= sh_nxt[23:0];
        end
        else if (sclk_fall && st_r == ST_DATA)
        begin
            dsh_r <= 8'(dbyte << out_w);
            dleft_r <= 4'(dleft - {1'b0, out_w});
            if (dleft_r == 4'h0)
            begin
                addr_r <= addr_adv; // [RULE24] [RULE17]
            end
        end
    end

    // Lane drivers turn on only at the first data fall
    always_ff @(posedge sys_clk or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            lane_out <= 4'h0;
            lane_oe <= 4'h0;
        end
        else if (frame_idle)
        begin
            lane_oe <= 4'h0; // [RULE27]
        end
        else if (sclk_fall && st_r == ST_DATA)
        begin
            lane_out <= nib;
            lane_oe <= lane_mask(out_w); // [RULE4]
        end
    end

    ////////////////////////////////////////////////////////////////
    // Memory port and status

    // Array sees the address well before the next byte is taken
    assign mem_addr = addr_r;
    assign mem_rd = (st_r == ST_DATA) & ~frame_idle;
    assign wrap_setting_bits = wrap_r;
    assign dummy_sel = dsel_r;
    assign execute_in_place = cont_r;
    assign read_busy = ~frame_idle;
endmodule

// >>> logic/mlfr_sync.sv
// Two-flop synchroniser for pins from outside the clock domain
module mlfr_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Asynchronous in, synchronised out
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;

    // First stage feeds only the second stage
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_r <= INIT;
            q <= INIT;
        end
        else
        begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule

// >>> verif/mlfr_host_model.sv
// Host controller model driving the serial link of the read path
module mlfr_host_model (
    // Link pins seen by the device
    output logic sclk,
    output logic cs_n,
    output logic [3:0] lane_in,
    // Device lane drivers
    input wire logic [3:0] lane_out,
    input wire logic [3:0] lane_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam real HALF = 62.5;
    logic [3:0] hval = 4'h0;
    logic hen = 1'b0;
    // Released lanes show the inverse of the last value, so a stale hold is never seen
    assign lane_in = (lane_oe & lane_out) | (~lane_oe & (hen ? hval : ~hval));
    // Clock parked low outside frames
    initial
    begin
        sclk = 1'b0;
        cs_n = 1'b1;
    end
    // One input clock; lanes let go 20 ns after the rise, well before the next fall
    task automatic tick(input logic [3:0] v, input logic drv);
        hval = v;
        hen = drv;
        #(HALF);
        sclk = 1'b1;
        #20;
        hen = 1'b0;
        #(HALF - 20);
        sclk = 1'b0;
    endtask
    // MSB first, w bits per clock
    task automatic send(input logic [31:0] v, input int nb, input int w);
        logic [31:0] t;
        for (int i = nb - w; i >= 0; i -= w)
        begin
            t = v >> i;
            tick(t[3:0] & ((4'h1 << w) - 4'h1), 1'b1);
        end
    endtask
    // Changing garbage on the lanes during dummy clocks
    task automatic dummy(input int n);
        for (int i = 0; i < n; i++)
            tick(4'(i) ^ 4'h5, 1'b0);
    endtask
    // Data byte sampled at each rise
    task automatic rx(input int w, output logic [7:0] b, output logic [3:0] oe);
        b = 8'h0;
        for (int k = 0; k < 8 / w; k++)
        begin
            hen = 1'b0;
            #(HALF);
            sclk = 1'b1;
            b = (b << w) | {4'h0, lane_in & ((4'h1 << w) - 4'h1)};
            oe = lane_oe;
            #(HALF);
            sclk = 1'b0;
        end
    endtask
    // Frame edges
    task automatic start();
        cs_n = 1'b0;
        #(HALF);
    endtask
    task automatic stop();
        #20;
        cs_n = 1'b1;
        #100;
    endtask
endmodule

// >>> verif/mlfr_read_path_monitor.sv
// Port checker for the multi-lane fast read path
module mlfr_read_path_monitor (
    // Clock, reset, link and configuration inputs
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic quad_enable_bit,
    input wire logic quad_command_mode,
    input wire logic dummy_sel_wr,
    input wire logic [1:0] dummy_sel_data,
    // Observed outputs
    input wire logic [3:0] lane_out,
    input wire logic [3:0] lane_oe,
    input wire logic [23:0] mem_addr,
    input wire logic mem_rd,
    input wire logic [2:0] wrap_setting_bits,
    input wire logic [1:0] dummy_sel,
    input wire logic execute_in_place,
    input wire logic read_busy
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    // Chip select high long enough to clear the pin synchronisers
    sequence s_cs_idle;
        cs_n [*6];
    endsequence
    ////////////////////////////////////////////////////////////////////////
    a_cfg_defaults: assert property (
        $rose(nrst) |-> wrap_setting_bits == 3'h1 && dummy_sel == 2'h0) else $error("Config defaults wrong");
    a_idle_quiet: assert property (
        s_cs_idle |-> lane_oe == 4'h0 && !read_busy) else $error("Lanes driven while deselected");
    a_oe_shape: assert property (
        lane_oe == 4'h0 || lane_oe == 4'h3 || lane_oe == 4'hf) else $error("Odd lane enable pattern");
    a_quad_needs_qe: assert property (
        lane_oe == 4'hf |-> quad_enable_bit) else $error("Quad output without quad enable");
    a_oe_in_data: assert property (
        lane_oe != 4'h0 |-> $past(mem_rd)) else $error("Lanes driven outside data phase");
    a_lane_on_fall: assert property (
        $changed(lane_out) |-> !sclk && !$past(sclk, 2)) else $error("Lane output moved off a clock fall");
    a_dummy_load: assert property (
        dummy_sel_wr |=> dummy_sel == $past(dummy_sel_data)) else $error("Dummy select not loaded");
    a_dummy_hold: assert property (
        !dummy_sel_wr |=> $stable(dummy_sel)) else $error("Dummy select changed unasked");
    a_wrap_change: assert property (
        $changed(wrap_setting_bits) |-> $past(read_busy) && !(quad_command_mode && quad_enable_bit))
        else $error("Wrap bits changed outside a single-lane frame");
    a_eip_change: assert property (
        $changed(execute_in_place) |-> $past(read_busy)) else $error("Continuous mode changed while idle");
    a_addr_step: assert property (
        $changed(mem_addr) && mem_rd && $past(lane_oe != 4'h0) && wrap_setting_bits[0]
        |-> mem_addr == $past(mem_addr) + 24'h1) else $error("Address did not step by one");
endmodule

// >>> verif/tb_top.sv
// Self-checking bench for the multi-lane fast read path
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin bad_count++; \
    $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import mlfr_pkg::*;
    localparam logic [23:0] LIN = 24'hffffff;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic qen = 1'b0;
    logic qcm = 1'b0;
    logic dsw = 1'b0;
    logic [1:0] dsd = 2'h0;
    logic sclk, cs_n, mem_rd, eip, busy;
    logic [3:0] lane_in, lane_out, lane_oe;
    logic [23:0] mem_addr;
    logic [7:0] mem_rdata;
    logic [2:0] wrap_bits;
    logic [1:0] dsel;
    int bad_count = 0;
    int num_checks = 0;
    int cyc = 0;
    // 250 MHz clock and a simple array whose byte depends on two address bytes
    initial forever #2 sys_clk = ~sys_clk;
    assign mem_rdata = mem_addr[7:0] ^ mem_addr[15:8] ^ 8'ha5;
    ////////////////////////////////////////////////////////////////////////
    mlfr_read_path u_dut (.sys_clk(sys_clk), .nrst(nrst), .sclk(sclk), .cs_n(cs_n), .lane_in(lane_in),
        .lane_out(lane_out), .lane_oe(lane_oe), .quad_enable_bit(qen), .quad_command_mode(qcm),
        .dummy_sel_wr(dsw), .dummy_sel_data(dsd), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_rdata(mem_rdata),
        .wrap_setting_bits(wrap_bits), .dummy_sel(dsel), .execute_in_place(eip), .read_busy(busy));
    mlfr_host_model u_host (.sclk(sclk), .cs_n(cs_n), .lane_in(lane_in), .lane_out(lane_out), .lane_oe(lane_oe));
    ////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Hang guard, about three and a half times the expected run
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 80000)
        begin
            `CHK("run_time", 1'b0, 1'b1)
            summarize();
        end
    end
    // Config levels change only while the link is idle
    task automatic cfg(input logic q, input logic m);
        @(posedge sys_clk);
        qen <= q;
        qcm <= m;
        repeat (4) @(posedge sys_clk);
    endtask
    task automatic set_dummy(input logic [1:0] v);
        @(posedge sys_clk);
        dsw <= 1'b1;
        dsd <= v;
        @(posedge sys_clk);
        dsw <= 1'b0;
        @(posedge sys_clk);
    endtask
    // One read frame; mode byte sent at address width when address is multi-lane
    task automatic rd(input logic [7:0] opc, input int ow, input logic [23:0] a, input int aw, input logic [7:0] m,
                      input int nd, input int dw, input int n, input logic [23:0] wm, input logic ok);
        logic [7:0] b;
        logic [3:0] oe;
        logic [23:0] ea;
        @(posedge sys_clk) #1.2; // Keeps pin edges off clock edges
        u_host.start();
        if (ow != 0)
            u_host.send({24'h0, opc}, 8, ow);
        u_host.send({8'h0, a}, 24, aw);
        if (aw != 1)
            u_host.send({24'h0, m}, 8, aw);
        u_host.dummy(nd);
        for (int k = 0; k < n; k++)
        begin
            u_host.rx(dw, b, oe);
            ea = (a & ~wm) | ((a + 24'(k)) & wm);
            `CHK("lane_oe", ok ? ((4'h1 << dw) - 4'h1) : 4'h0, oe)
            if (ok)
                `CHK("data", ea[7:0] ^ ea[15:8] ^ 8'ha5, b)
        end
        u_host.stop();
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (12) @(posedge sys_clk);
        nrst <= 1'b1;
        repeat (10) @(posedge sys_clk);
        `CHK("wrap_bits", 3'h1, wrap_bits)
        `CHK("dummy_sel", 2'h0, dsel)
        `CHK("busy", 1'b0, busy)
        cfg(1'b0, 1'b1);
        rd(OPC_DOUT2, 1, 24'h012345, 1, 8'h0, 8, 2, 3, LIN, 1'b1);
        rd(OPC_DOUT4, 1, 24'h0abcde, 1, 8'h0, 8, 4, 1, LIN, 1'b0);
        rd(OPC_DIO4, 1, 24'h0abcde, 4, 8'h0, 4, 4, 1, LIN, 1'b0);
        cfg(1'b1, 1'b0);
        rd(OPC_DOUT4, 1, 24'h0abcfe, 1, 8'h0, 8, 4, 3, LIN, 1'b1);
        $display("test output reads done");
        rd(OPC_DIO2, 1, 24'h1000fe, 2, 8'h2f, 0, 2, 3, LIN, 1'b1);
        `CHK("eip", 1'b1, eip)
        rd(8'h0, 0, 24'h200010, 2, 8'h20, 0, 2, 2, LIN, 1'b1);
        u_host.start();
        u_host.send(32'hffff, 16, 1);
        u_host.stop();
        `CHK("eip", 1'b0, eip)
        rd(OPC_DIO2, 1, 24'h300000, 2, 8'h00, 0, 2, 2, LIN, 1'b1);
        $display("test dual io done");
        rd(OPC_DIO4, 1, 24'h4000f0, 4, 8'h2a, 4, 4, 2, LIN, 1'b1);
        `CHK("eip", 1'b1, eip)
        rd(8'h0, 0, 24'h400100, 4, 8'h20, 4, 4, 2, LIN, 1'b1);
        u_host.start();
        u_host.send(32'hff, 8, 1);
        u_host.stop();
        `CHK("eip", 1'b0, eip)
        $display("test quad io done");
        // Every section length, read across the section end
        for (int l = 0; l < 4; l++)
        begin
            u_host.start();
            u_host.send({24'h0, OPC_WRAP}, 8, 1);
            u_host.send({25'h0, 2'(l), 5'h0}, 32, 1);
            u_host.stop();
            `CHK("wrap_bits", {2'(l), 1'b0}, wrap_bits)
            rd(OPC_DIO4, 1, 24'h000200 + 24'((8 << l) - 1), 4, 8'h0, 4, 4, 2, 24'((8 << l) - 1), 1'b1);
        end
        $display("test wrap done");
        cfg(1'b1, 1'b1);
        rd(OPC_DIO4, 4, 24'h500000, 4, 8'h20, 0, 4, 1, LIN, 1'b1);
        `CHK("eip", 1'b1, eip)
        rd(8'h0, 0, 24'h500040, 4, 8'h00, 0, 4, 1, LIN, 1'b1);
        `CHK("eip", 1'b0, eip)
        // Wrap is still enabled here, yet quad command reads stay linear
        for (int d = 0; d < 4; d++)
        begin
            set_dummy(2'(d));
            `CHK("dummy_sel", 2'(d), dsel)
            rd(OPC_DIO4, 4, 24'h00033f, 4, 8'h0, 2 * d, 4, 2, LIN, 1'b1);
        end
        $display("test quad command done");
        cfg(1'b1, 1'b0);
        summarize();
    end
endmodule
bind mlfr_read_path mlfr_read_path_monitor u_mon (.sys_clk(sys_clk), .nrst(nrst), .sclk(sclk), .cs_n(cs_n),
    .quad_enable_bit(quad_enable_bit), .quad_command_mode(quad_command_mode), .dummy_sel_wr(dummy_sel_wr),
    .dummy_sel_data(dummy_sel_data), .lane_out(lane_out), .lane_oe(lane_oe), .mem_addr(mem_addr), .mem_rd(mem_rd),
    .wrap_setting_bits(wrap_setting_bits), .dummy_sel(dummy_sel), .execute_in_place(execute_in_place),
    .read_busy(read_busy));
